/* File: verilog/crc_tx_request.sv */
// message-object transmit requests, cancellation and hand-off race
`timescale 1ns/100ps
`default_nettype none
// How it works
// - fourteen objects, each with four software-reached flags
// - update set, request clear, valid clear cancel
// - cancel at hand-off: accepted, content copy blocked
// - blocked copy sends remote frame, id 0, dlc 0
// - race only with a single active request
// - spurious frame never retransmitted after loss/error
// - stored remote frame keeps object dlc unchanged
module crc_tx_request #(
  parameter int NUM_OBJ = crc_pkg::NUM_OBJ
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // software access to per-object flags, one strobe per action
  input wire logic [NUM_OBJ-1:0] i_txrq_set,
  input wire logic [NUM_OBJ-1:0] i_txrq_clr,
  input wire logic [NUM_OBJ-1:0] i_cpuupd_set,
  input wire logic [NUM_OBJ-1:0] i_cpuupd_clr,
  input wire logic [NUM_OBJ-1:0] i_valid_set,
  input wire logic [NUM_OBJ-1:0] i_valid_clr,
  input wire logic [NUM_OBJ-1:0] i_new_data_flag_clr,
  // object contents written by software
  input wire logic [NUM_OBJ-1:0] i_content_we,
  input wire logic [crc_pkg::ID_W-1:0] i_wr_id,
  input wire logic [crc_pkg::DLC_W-1:0] i_wr_dlc,
  input wire logic [crc_pkg::DATA_W-1:0] i_wr_data,
  // received remote frame stored into an object
  input wire logic [NUM_OBJ-1:0] i_rx_remote,
  // flag state
  output logic [NUM_OBJ-1:0] o_transmit_request_flag,
  output logic [NUM_OBJ-1:0] o_cpu_update_flag,
  output logic [NUM_OBJ-1:0] o_object_valid_flag,
  output logic [NUM_OBJ-1:0] o_new_data_flag,
  output logic [NUM_OBJ*crc_pkg::DLC_W-1:0] o_obj_dlc,
  // protocol state machine side
  input wire logic i_sof_handoff,
  input wire logic i_frame_done,
  input wire logic i_frame_failed,
  // frame descriptor towards the bit engine
  output logic o_frame_valid,
  input wire logic i_frame_ready,
  output logic o_frame_remote,
  output logic [crc_pkg::ID_W-1:0] o_frame_id,
  output logic [crc_pkg::DLC_W-1:0] o_frame_dlc,
  output logic [crc_pkg::DATA_W-1:0] o_frame_data,
  output logic o_frame_spurious
);
  localparam int DESC_W = 2 + crc_pkg::ID_W + crc_pkg::DLC_W + crc_pkg::DATA_W;

  // one frame in flight at a time, so idle and wait are all the states needed
  typedef enum logic [1:0] {
    CRC_IDLE = 2'b00,
    CRC_WAIT = 2'b01
  } crc_state_t;

  logic [NUM_OBJ-1:0] txrq;
  logic [NUM_OBJ-1:0] cpuupd;
  logic [NUM_OBJ-1:0] msgval;
  logic [NUM_OBJ-1:0] new_data_flag;
  logic [NUM_OBJ-1:0] pending;
  logic [NUM_OBJ-1:0] cancel;
  logic [crc_pkg::ID_W-1:0] obj_id [NUM_OBJ];
  logic [crc_pkg::DLC_W-1:0] obj_dlc [NUM_OBJ];
  logic [crc_pkg::DATA_W-1:0] obj_data [NUM_OBJ];
  crc_state_t state;
  logic [3:0] sel;
  logic [3:0] cur;
  logic cur_spurious;
  logic race;
  logic [$clog2(NUM_OBJ+1)-1:0] n_pending;
  logic take;
  logic buf_ready;
  logic [DESC_W-1:0] desc;
  logic [DESC_W-1:0] buf_out;

  // pending: request set, valid, not being updated
  assign pending = txrq & msgval & ~cpuupd;
  // any of the three cancel actions in this cycle
  assign cancel = i_cpuupd_set | i_txrq_clr | i_valid_clr;

  always_comb
  begin
    sel = crc_pkg::IDX_NONE;
    n_pending = '0;
    for (int k = NUM_OBJ - 1; k >= 0; k--)
    begin
      if (pending[k])
      begin
        sel = 4'(k);
        n_pending = n_pending + 1'b1;
      end
    end
  end

  // hand-off accepts lowest pending object; back-pressure stalls it
  assign take = (state == CRC_IDLE) && i_sof_handoff && (sel != crc_pkg::IDX_NONE)
                && buf_ready;
  // race: cancel lands on the sole pending object at the hand-off
  assign race = take && cancel[sel] && (n_pending == 1);

  genvar g;
  generate
    for (g = 0; g < NUM_OBJ; g++)
    begin : g_obj
      always_ff @(posedge i_core_clk or posedge i_rst)
      begin
        if (i_rst)
        begin
          txrq[g] <= 1'b0;
          cpuupd[g] <= 1'b0;
          msgval[g] <= 1'b0;
          new_data_flag[g] <= 1'b0;
          obj_dlc[g] <= crc_pkg::DLC_RESET;
        end
        else
        begin
          // software sets win over clears on the same object
          if (i_txrq_set[g])
            txrq[g] <= 1'b1;
          else if (i_txrq_clr[g])
            txrq[g] <= 1'b0;
          else if (state == CRC_WAIT && !cur_spurious && cur == 4'(g) && i_frame_done)
            txrq[g] <= 1'b0;
          if (i_cpuupd_set[g])
            cpuupd[g] <= 1'b1;
          else if (i_cpuupd_clr[g])
            cpuupd[g] <= 1'b0;
          if (i_valid_set[g])
            msgval[g] <= 1'b1;
          else if (i_valid_clr[g])
            msgval[g] <= 1'b0;
          // hardware set wins over software clear
          if (i_content_we[g])
            new_data_flag[g] <= 1'b1;
          else if (take && !race && sel == 4'(g))
            new_data_flag[g] <= 1'b0;
          else if (i_new_data_flag_clr[g])
            new_data_flag[g] <= 1'b0;
          if (i_content_we[g])
            obj_dlc[g] <= i_wr_dlc;
          else if (i_rx_remote[g])
            obj_dlc[g] <= obj_dlc[g];
        end
      end

      always_ff @(posedge i_core_clk)
      begin
        if (i_content_we[g])
        begin
          obj_id[g] <= i_wr_id;
          obj_data[g] <= i_wr_data;
        end
      end

      assign o_obj_dlc[g*crc_pkg::DLC_W +: crc_pkg::DLC_W] = obj_dlc[g];
    end
  endgenerate

  // descriptor: spurious uses constant zero id, dlc and data, else object copy
  always_comb
  begin
    if (race)
      desc = {1'b1, 1'b1, crc_pkg::SPURIOUS_ID, crc_pkg::SPURIOUS_DLC,
              {crc_pkg::DATA_W{1'b0}}};
    else if (sel != crc_pkg::IDX_NONE)
      desc = {1'b0, 1'b0, obj_id[sel], obj_dlc[sel], obj_data[sel]};
    else
      desc = '0;
  end

  // frame sequencing: failure retries real frames, drops the spurious one
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state <= CRC_IDLE;
      cur <= crc_pkg::IDX_NONE;
      cur_spurious <= 1'b0;
    end
    else
    begin
      case (state)
        CRC_IDLE:
        begin
          if (take)
          begin
            state <= CRC_WAIT;
            cur <= sel;
            cur_spurious <= race;
          end
        end
        CRC_WAIT:
        begin
          // real frame retries by staying pending; spurious one is gone
          if (i_frame_done || i_frame_failed)
          begin
            state <= CRC_IDLE;
            cur_spurious <= 1'b0;
          end
        end
        default:
          state <= CRC_IDLE;
      endcase
    end
  end

  crc_frame_buf #(
    .WIDTH(DESC_W)
  ) u_buf (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_valid(take),
    .o_ready(buf_ready),
    .i_data(desc),
    .o_valid(o_frame_valid),
    .i_ready(i_frame_ready),
    .o_data(buf_out)
  );

  assign o_frame_spurious = buf_out[DESC_W-1];
  assign o_frame_remote = buf_out[DESC_W-2];
  assign o_frame_id = buf_out[crc_pkg::DLC_W+crc_pkg::DATA_W +: crc_pkg::ID_W];
  assign o_frame_dlc = buf_out[crc_pkg::DATA_W +: crc_pkg::DLC_W];
  assign o_frame_data = buf_out[crc_pkg::DATA_W-1:0];
  assign o_transmit_request_flag = txrq;
  assign o_cpu_update_flag = cpuupd;
  assign o_object_valid_flag = msgval;
  assign o_new_data_flag = new_data_flag;
endmodule : crc_tx_request
`default_nettype wire

/* File: verilog/crc_pkg.sv */
// constants shared by the transmit-request block
`default_nettype none
package crc_pkg;
  localparam int NUM_OBJ = 14;
  localparam int ID_W = 11;
  localparam int DLC_W = 4;
  localparam int DATA_W = 64;
  localparam logic [10:0] SPURIOUS_ID = 11'h000;
  localparam logic [3:0] SPURIOUS_DLC = 4'h0;
  localparam logic [3:0] DLC_RESET = 4'h0;
  localparam logic [3:0] IDX_NONE = 4'hf;
  localparam int BUF_DEPTH = 2;
endpackage : crc_pkg
`default_nettype wire

/* File: verilog/crc_frame_buf.sv */
// two-entry buffer for outgoing frame descriptors
`timescale 1ns/100ps
`default_nettype none
module crc_frame_buf #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // fill side
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  // drain side
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  logic [WIDTH-1:0] mem [2];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic push;
  logic pop;

  assign o_ready = (count != 2'h2);
  assign o_valid = (count != 2'h0);
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;
  assign o_data = mem[rd_ptr];

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end
    else
    begin
      if (push)
        wr_ptr <= ~wr_ptr;
      if (pop)
        rd_ptr <= ~rd_ptr;
      if (push && !pop)
        count <= count + 2'h1;
      else if (pop && !push)
        count <= count - 2'h1;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (push)
      mem[wr_ptr] <= i_data;
  end
endmodule : crc_frame_buf
`default_nettype wire

/* File: testbench/crc_checker.sv */
// port assertions for the transmit-request block
`timescale 1ns/100ps
`default_nettype none
module crc_checker (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [13:0] i_txrq_set,
  input wire logic [13:0] i_txrq_clr,
  input wire logic [13:0] i_valid_set,
  input wire logic [13:0] i_valid_clr,
  input wire logic [13:0] i_rx_remote,
  input wire logic [13:0] o_transmit_request_flag,
  input wire logic [13:0] o_object_valid_flag,
  input wire logic [55:0] o_obj_dlc,
  input wire logic o_frame_valid,
  input wire logic i_frame_ready,
  input wire logic o_frame_remote,
  input wire logic [10:0] o_frame_id,
  input wire logic [3:0] o_frame_dlc,
  input wire logic o_frame_spurious
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  spur_zero_a: assert property (o_frame_valid && o_frame_spurious |-> o_frame_remote
    && o_frame_id == 11'h000 && o_frame_dlc == 4'h0) else $error("spurious content");
  data_plain_a: assert property (o_frame_valid && !o_frame_remote |-> !o_frame_spurious)
    else $error("data frame marked spurious");
  desc_hold_a: assert property (o_frame_valid && !i_frame_ready |=> o_frame_valid
    && $stable(o_frame_id)) else $error("descriptor moved");
  req_set_a: assert property (|i_txrq_set |=>
    (o_transmit_request_flag & $past(i_txrq_set)) == $past(i_txrq_set)) else $error("set lost");
  req_clr_a: assert property (|i_txrq_clr && !(|i_txrq_set) |=>
    (o_transmit_request_flag & $past(i_txrq_clr)) == 14'h0) else $error("request clear lost");
  valid_set_a: assert property (|i_valid_set |=>
    (o_object_valid_flag & $past(i_valid_set)) == $past(i_valid_set)) else $error("valid lost");
  valid_clr_a: assert property (|i_valid_clr && !(|i_valid_set) |=>
    (o_object_valid_flag & $past(i_valid_clr)) == 14'h0) else $error("valid clear lost");
  dlc_keep_a: assert property (|i_rx_remote |=> $stable(o_obj_dlc))
    else $error("remote changed dlc");
  spur_once_a: assert property (o_frame_valid && o_frame_spurious && i_frame_ready |=>
    !(o_frame_valid && o_frame_spurious) [*3]) else $error("spurious frame repeated");
  cover property (o_frame_valid && o_frame_spurious && i_frame_ready);
  cover property (o_frame_valid && !o_frame_remote && i_frame_ready);
  cover property (o_frame_valid && !i_frame_ready);
endmodule : crc_checker
`default_nettype wire

/* File: testbench/crc_engine_model.sv */
// far-side frame engine: stalls, takes a descriptor, then ends the frame
`timescale 1ns/100ps
`default_nettype none
module crc_engine_model (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_frame_valid,
  input wire logic [3:0] i_stall,
  input wire logic i_fail,
  output logic o_ready,
  output logic o_done,
  output logic o_failed
);
  logic [3:0] cnt;
  // ready pulses once per descriptor so a stale frame is never taken twice
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_ready <= 1'b0;
      o_done <= 1'b0;
      o_failed <= 1'b0;
      cnt <= 4'h0;
    end
    else
    begin
      o_done <= o_ready && !i_fail;
      o_failed <= o_ready && i_fail;
      o_ready <= i_frame_valid && !o_ready && cnt == i_stall;
      cnt <= (i_frame_valid && !o_ready && cnt != i_stall) ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule : crc_engine_model
`default_nettype wire

/* File: testbench/testbench.sv */
// bench for the transmit-request block: normal frames, cancels and the hand-off race
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("FAIL %s exp %h got %h", n, e, g); end end
module testbench;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [13:0] i_txrq_set, i_txrq_clr, i_cpuupd_set, i_cpuupd_clr, i_valid_set, i_valid_clr;
  logic [13:0] i_new_data_flag_clr, i_content_we, i_rx_remote, o_transmit_request_flag;
  logic [13:0] o_cpu_update_flag, o_object_valid_flag, o_new_data_flag;
  logic [55:0] o_obj_dlc;
  logic [10:0] i_wr_id, o_frame_id;
  logic [3:0] i_wr_dlc, o_frame_dlc, stall;
  logic [63:0] i_wr_data, o_frame_data;
  logic i_sof_handoff, i_frame_done, i_frame_failed, o_frame_valid, i_frame_ready;
  logic o_frame_remote, o_frame_spurious, fail;
  int error_cnt = 0;
  int cmp_count = 0;
  always #5 i_core_clk = ~i_core_clk;
  crc_engine_model eng (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_frame_valid(o_frame_valid),
    .i_stall(stall),
    .i_fail(fail),
    .o_ready(i_frame_ready),
    .o_done(i_frame_done),
    .o_failed(i_frame_failed)
  );
  crc_tx_request uut (.*);
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  task automatic idle;
    {i_txrq_set, i_txrq_clr, i_cpuupd_set, i_cpuupd_clr, i_valid_set} = '0;
    {i_valid_clr, i_new_data_flag_clr, i_content_we, i_rx_remote} = '0;
    i_sof_handoff = 1'b0;
  endtask : idle
  task automatic step;
    @(posedge i_core_clk);
    #1;
    idle();
  endtask : step
  // sel 0 waits for a descriptor, sel 1 for the end of the frame
  task automatic wait_sig(input bit sel);
    int n;
    n = 0;
    while ((sel ? (i_frame_done | i_frame_failed) : o_frame_valid) !== 1'b1)
    begin
      step();
      n++;
      if (n > 20)
      begin
        error_cnt++;
        report_and_stop();
      end
    end
  endtask : wait_sig
  // hand-off, with object 3 cancelled in the same cycle by method m
  task automatic send(input int m, input logic [10:0] id, input logic [3:0] dlc, input logic sp);
    i_sof_handoff = 1'b1;
    i_cpuupd_set[3] = (m == 1);
    i_txrq_clr[3] = (m == 2);
    i_valid_clr[3] = (m == 3);
    step();
    wait_sig(1'b0);
    `CHK("id", id, o_frame_id)
    `CHK("dlc", dlc, o_frame_dlc)
    `CHK("data", sp ? 64'h0 : i_wr_data, o_frame_data)
    `CHK("spurious", sp, o_frame_spurious)
    `CHK("remote", sp, o_frame_remote)
    wait_sig(1'b1);
    step();
  endtask : send
  initial
  begin
    idle();
    fail = 1'b0;
    stall = 4'h3;
    i_wr_id = 11'h5a5;
    i_wr_dlc = 4'h8;
    i_wr_data = 64'h0123456789abcdef;
    repeat (12) @(posedge i_core_clk);
    #1;
    i_rst = 1'b0;
    `CHK("flags", 28'h0, {o_transmit_request_flag, o_object_valid_flag})
    `CHK("dlcs", 56'h0, o_obj_dlc)
    i_content_we[3] = 1'b1;
    i_valid_set[3] = 1'b1;
    i_txrq_set[3] = 1'b1;
    step();
    `CHK("new data", 1'b1, o_new_data_flag[3])
    send(0, 11'h5a5, 4'h8, 1'b0);
    `CHK("request", 1'b0, o_transmit_request_flag[3])
    `CHK("new data taken", 1'b0, o_new_data_flag[3])
    stall = 4'h0;
    for (int m = 1; m < 4; m++)
    begin
      fail = (m != 1);
      i_valid_set[3] = 1'b1;
      i_cpuupd_clr[3] = 1'b1;
      i_txrq_set[3] = 1'b1;
      step();
      send(m, 11'h000, 4'h0, 1'b1);
      `CHK("update", m == 1, o_cpu_update_flag[3])
      `CHK("valid", m != 3, o_object_valid_flag[3])
      i_sof_handoff = 1'b1;
      step();
      step();
      `CHK("no resend", 1'b0, o_frame_valid)
    end
    fail = 1'b0;
    i_wr_id = 11'h123;
    i_content_we[5] = 1'b1;
    i_valid_set = 14'h0028;
    i_txrq_set = 14'h0028;
    i_cpuupd_clr[3] = 1'b1;
    step();
    send(2, 11'h5a5, 4'h8, 1'b0);
    send(0, 11'h123, 4'h8, 1'b0);
    i_rx_remote[3] = 1'b1;
    step();
    `CHK("stored dlc", 4'h8, o_obj_dlc[15:12])
    fail = 1'b1;
    i_txrq_set[5] = 1'b1;
    step();
    send(0, 11'h123, 4'h8, 1'b0);
    `CHK("retry pending", 1'b1, o_transmit_request_flag[5])
    fail = 1'b0;
    send(0, 11'h123, 4'h8, 1'b0);
    `CHK("retry done", 1'b0, o_transmit_request_flag[5])
    i_content_we[7] = 1'b1;
    i_new_data_flag_clr[7] = 1'b1;
    step();
    `CHK("new data set wins", 1'b1, o_new_data_flag[7])
    i_new_data_flag_clr[7] = 1'b1;
    step();
    `CHK("new data clear", 1'b0, o_new_data_flag[7])
    report_and_stop();
  end
endmodule : testbench
bind crc_tx_request crc_checker chk (.*);
`default_nettype wire
